// *** include/asw_pkg.sv ***
package asw_pkg;

  localparam int unsigned ADDR_W  = 18;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned CLK_NS  = 50;

  // Write timing figures in nanoseconds (slower grade, covers both).
  localparam int unsigned T_CYCLE_NS    = 15;
  localparam int unsigned T_PULSE_NS    = 12;
  localparam int unsigned T_ADDR_END_NS = 12;
  localparam int unsigned T_DATA_END_NS = 7;
  localparam int unsigned T_QZ_NS       = 7;

  // Least times round up, and no count is under one cycle.
  localparam int unsigned PULSE_CYC_RAW = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PULSE_CYC = (PULSE_CYC_RAW < 1) ? 1 : PULSE_CYC_RAW;
  localparam int unsigned QZ_CYC_RAW = (T_QZ_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned QZ_CYC = (QZ_CYC_RAW < 1) ? 1 : QZ_CYC_RAW;
  localparam int unsigned CNT_W = 4;

  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_PULSE = 2'b11,
    ST_END   = 2'b10
  } asw_state_e;

  typedef enum logic [1:0] {
    WM_STROBE = 2'b00,
    WM_CHIP   = 2'b01,
    WM_LANE   = 2'b10
  } asw_mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [1:0]        lanes;
    asw_mode_e         mode;
  } asw_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr_pins;
    logic              chip_sel_n;
    logic              wr_strobe_n;
    logic              out_gate_n;
    logic              low_lane_sel_n;
    logic              high_lane_sel_n;
  } asw_pins_s;

endpackage

// *** rtl/asw_lane_drive.sv ***
`timescale 1ns/1ps
module asw_lane_drive
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      load,
  input  wire logic                      drive,
  input  wire logic [asw_pkg::DATA_W-1:0] data_in,
  input  wire logic [1:0]                lanes,
  output logic      [asw_pkg::DATA_W-1:0] data_out,
  output logic      [asw_pkg::DATA_W-1:0] data_oe_n
);

  logic [asw_pkg::DATA_W-1:0] data_q;
  logic [asw_pkg::DATA_W-1:0] data_d;
  logic [asw_pkg::DATA_W-1:0] oe_n_q;
  logic [asw_pkg::DATA_W-1:0] oe_n_d;

  // Each lane drives its own byte only while it is selected.
  genvar g;
  for (g = 0; g < 2; g++)
  begin : g_lane
    always_comb
    begin
      data_d[g*8 +: 8] = load ? data_in[g*8 +: 8] : data_q[g*8 +: 8];
      oe_n_d[g*8 +: 8] = (drive && lanes[g]) ? 8'h00 : 8'hff;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_q <= asw_pkg::DATA_RST;
      oe_n_q <= 16'hffff;
    end
    else
    begin
      data_q <= data_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign data_out  = data_q;
  assign data_oe_n = oe_n_q;

endmodule

// *** rtl/asw_host.sv ***
`timescale 1ns/1ps
module asw_host
(
  input  wire logic                          CLK_SYS,
  input  wire logic                          SYS_RST,
  input  wire logic                          REQ_VALID,
  output logic                               REQ_READY,
  input  wire asw_pkg::asw_req_s             REQ,
  output logic                               DONE,
  output asw_pkg::asw_pins_s                 PINS,
  output logic      [asw_pkg::DATA_W-1:0]    DATA_PINS_OUT,
  output logic      [asw_pkg::DATA_W-1:0]    DATA_PINS_OE_N
);

  asw_pkg::asw_state_e              state_q;
  asw_pkg::asw_state_e              state_d;
  asw_pkg::asw_req_s                req_q;
  asw_pkg::asw_req_s                req_d;
  logic [asw_pkg::CNT_W-1:0]        cnt_q;
  logic [asw_pkg::CNT_W-1:0]        cnt_d;
  asw_pkg::asw_pins_s               pins_q;
  asw_pkg::asw_pins_s               pins_d;
  logic                             done_q;
  logic                             done_d;
  logic                             load;
  logic                             drive;
  logic [1:0]                       lane_en;

  assign REQ_READY = (state_q == asw_pkg::ST_IDLE);
  assign load      = REQ_VALID && REQ_READY;
  assign lane_en   = (req_q.lanes == 2'b00) ? 2'b11 : req_q.lanes;

  always_comb
  begin
    state_d = state_q;
    req_d   = req_q;
    cnt_d   = cnt_q;
    pins_d  = pins_q;
    done_d  = 1'b0;
    drive   = 1'b0;
    case (state_q)
      asw_pkg::ST_IDLE:
      begin
        pins_d.chip_sel_n      = 1'b1;
        pins_d.wr_strobe_n     = 1'b1;
        pins_d.low_lane_sel_n  = 1'b1;
        pins_d.high_lane_sel_n = 1'b1;
        pins_d.out_gate_n      = 1'b1;
        if (load)
        begin
          req_d          = REQ;
          pins_d.addr_pins = REQ.addr;
          state_d        = asw_pkg::ST_SETUP;
        end
      end
      asw_pkg::ST_SETUP:
      begin
        // Address has been stable a cycle; lower all but the mode's controlling strobe, which opens the write in ST_PULSE.
        cnt_d = '0;
        drive = 1'b1;
        state_d = asw_pkg::ST_PULSE;
        case (req_q.mode)
          asw_pkg::WM_CHIP:
          begin
            pins_d.wr_strobe_n     = 1'b0;
            pins_d.low_lane_sel_n  = ~lane_en[0];
            pins_d.high_lane_sel_n = ~lane_en[1];
          end
          asw_pkg::WM_LANE:
          begin
            pins_d.chip_sel_n  = 1'b0;
            pins_d.wr_strobe_n = 1'b0;
          end
          default:
          begin
            pins_d.chip_sel_n      = 1'b0;
            pins_d.low_lane_sel_n  = ~lane_en[0];
            pins_d.high_lane_sel_n = ~lane_en[1];
          end
        endcase
      end
      asw_pkg::ST_PULSE:
      begin
        drive = 1'b1;
        // Chip select, write strobe and the enabled lane selects go low here, so the write interval is open.
        pins_d.chip_sel_n      = 1'b0;
        pins_d.wr_strobe_n     = 1'b0;
        pins_d.low_lane_sel_n  = ~lane_en[0];
        pins_d.high_lane_sel_n = ~lane_en[1];
        cnt_d = cnt_q + 4'h1;
        if (cnt_q >= 4'(asw_pkg::PULSE_CYC))
        begin
          state_d = asw_pkg::ST_END;
          case (req_q.mode)
            asw_pkg::WM_CHIP:
              pins_d.chip_sel_n = 1'b1;
            asw_pkg::WM_LANE:
            begin
              pins_d.low_lane_sel_n  = 1'b1;
              pins_d.high_lane_sel_n = 1'b1;
            end
            default:
              pins_d.wr_strobe_n = 1'b1;
          endcase
        end
      end
      asw_pkg::ST_END:
      begin
        // Address and data held one more cycle past the ending edge.
        pins_d.chip_sel_n      = 1'b1;
        pins_d.wr_strobe_n     = 1'b1;
        pins_d.low_lane_sel_n  = 1'b1;
        pins_d.high_lane_sel_n = 1'b1;
        done_d  = 1'b1;
        state_d = asw_pkg::ST_IDLE;
      end
      default:
        state_d = asw_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state_q <= asw_pkg::ST_IDLE;
      req_q   <= '0;
      cnt_q   <= '0;
      pins_q  <= '{addr_pins: asw_pkg::ADDR_RST, default: 1'b1};
      done_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      req_q   <= req_d;
      cnt_q   <= cnt_d;
      pins_q  <= pins_d;
      done_q  <= done_d;
    end
  end

  asw_lane_drive u_lane
  (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .load      (load),
    .drive     (drive),
    .data_in   (REQ.data),
    .lanes     (lane_en),
    .data_out  (DATA_PINS_OUT),
    .data_oe_n (DATA_PINS_OE_N)
  );

  assign PINS = pins_q;
  assign DONE = done_q;

endmodule

// *** dv/asw_sram_model.sv ***
`timescale 1ns/1ps
module asw_sram_model
(
  input wire logic               clk,
  input wire asw_pkg::asw_pins_s pins,
  input wire logic [15:0]        dq
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] v;
  // The model never drives dq.
  always @(posedge clk)
    if (!pins.chip_sel_n && !pins.wr_strobe_n)
    begin
      v = mem.exists(pins.addr_pins) ? mem[pins.addr_pins] : 16'hxxxx;
      if (!pins.low_lane_sel_n) v[7:0] = dq[7:0];
      if (!pins.high_lane_sel_n) v[15:8] = dq[15:8];
      mem[pins.addr_pins] = v;
    end
endmodule

// *** dv/asw_host_asserts.sv ***
`timescale 1ns/1ps
module asw_host_asserts
(
  input wire logic               CLK_SYS,
  input wire logic               SYS_RST,
  input wire logic               REQ_VALID,
  input wire logic               REQ_READY,
  input wire asw_pkg::asw_req_s  REQ,
  input wire logic               DONE,
  input wire asw_pkg::asw_pins_s PINS,
  input wire logic [15:0]        DATA_PINS_OUT,
  input wire logic [15:0]        DATA_PINS_OE_N
);
  logic t;
  logic w;
  assign t = REQ_VALID && REQ_READY;
  assign w = !PINS.chip_sel_n && !PINS.wr_strobe_n
             && !(PINS.low_lane_sel_n && PINS.high_lane_sel_n);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  property p_gate; PINS.out_gate_n; endproperty
  property p_addr;
    t |=> PINS.addr_pins == $past(REQ.addr) ##1 $stable(PINS.addr_pins)[*4];
  endproperty
  property p_win; t |-> ##2 !w ##1 w ##1 !w; endproperty
  property p_data;
    t |-> ##3 ((DATA_PINS_OUT ^ $past(REQ.data, 3)) & ~DATA_PINS_OE_N) == 0;
  endproperty
  property p_setup; $rose(w) |-> $stable(DATA_PINS_OUT); endproperty
  property p_lane;
    w |-> DATA_PINS_OE_N == {{8{PINS.high_lane_sel_n}},
                             {8{PINS.low_lane_sel_n}}};
  endproperty
  property p_done; t |-> ##5 DONE ##1 !DONE; endproperty
  property p_busy; t |=> !REQ_READY [*4] ##1 REQ_READY; endproperty
  property p_term;
    t && REQ.mode == asw_pkg::WM_LANE |-> ##4 !PINS.chip_sel_n
      && !PINS.wr_strobe_n && PINS.low_lane_sel_n && PINS.high_lane_sel_n;
  endproperty
  a_gate: assert property (p_gate) else $error("gate low");
  a_addr: assert property (p_addr) else $error("addr moved");
  a_win: assert property (p_win) else $error("bad write window");
  a_data: assert property (p_data) else $error("bad data");
  a_setup: assert property (p_setup) else $error("data late");
  a_lane: assert property (p_lane) else $error("lane drive");
  a_done: assert property (p_done) else $error("done timing");
  a_busy: assert property (p_busy) else $error("ready timing");
  a_term: assert property (p_term) else $error("lane end");
  c_strobe: cover property (t && REQ.mode == asw_pkg::WM_STROBE);
  c_chip: cover property (t && REQ.mode == asw_pkg::WM_CHIP);
  c_lane: cover property (t && REQ.mode == asw_pkg::WM_LANE);
endmodule
bind asw_host asw_host_asserts asw_host_asserts_inst
(
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REQ(REQ), .DONE(DONE), .PINS(PINS),
  .DATA_PINS_OUT(DATA_PINS_OUT), .DATA_PINS_OE_N(DATA_PINS_OE_N)
);

// *** dv/asw_host_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      n_fail++; \
      $display("Error %0t: got %h exp %h", $time, a, b); \
    end \
  end
module asw_host_tb;
  logic               clk_sys;
  logic               sys_rst;
  logic               req_valid;
  logic               req_ready;
  logic               done;
  logic [15:0]        dq_out;
  logic [15:0]        dq_oe_n;
  wire logic [15:0]   dq;
  asw_pkg::asw_req_s  req;
  asw_pkg::asw_pins_s pins;
  logic [15:0]        exp_m [logic [17:0]];
  int                 n_fail;
  int                 total_checks;
  assign dq = dq_out ^ dq_oe_n;
  asw_host asw_host_inst
  (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ(req), .DONE(done), .PINS(pins),
    .DATA_PINS_OUT(dq_out), .DATA_PINS_OE_N(dq_oe_n)
  );
  asw_sram_model asw_sram_model_inst (.clk(clk_sys), .pins(pins), .dq(dq));
  function automatic asw_pkg::asw_req_s rnd(input logic [1:0] m, l);
    rnd.addr = 18'($urandom % 4);
    rnd.data = 16'($urandom);
    rnd.lanes = l;
    rnd.mode = asw_pkg::asw_mode_e'(m);
  endfunction
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input asw_pkg::asw_req_s r);
    logic [1:0]  ln;
    logic [15:0] e;
    ln = (r.lanes == 2'h0) ? 2'h3 : r.lanes;
    e = exp_m.exists(r.addr) ? exp_m[r.addr] : 16'hxxxx;
    if (ln[0]) e[7:0] = r.data[7:0];
    if (ln[1]) e[15:8] = r.data[15:8];
    exp_m[r.addr] = e;
    @(posedge clk_sys);
    req <= r;
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req <= rnd(2'($urandom % 3), 2'($urandom));
    repeat (2) @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
    `CHK(req_ready, 1'b0)
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(done, 1'b1)
    `CHK(req_ready, 1'b1)
    `CHK(pins.addr_pins, r.addr)
    `CHK(pins[4:0], 5'h1f)
    `CHK(dq_oe_n, 16'hffff)
    `CHK(asw_sram_model_inst.mem[r.addr], e)
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(96));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    `CHK(pins, {18'h00000, 5'h1f})
    for (int i = 0; i < 24; i++)
      wr(rnd(2'(i % 3), 2'(i / 3)));
    complete_run();
  end
endmodule
